// ===== hvrb_pkg.sv
package hvrb_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int REG_COUNT = 128;
    localparam int IDX_W = 7;
    localparam int BLK_W = 4;
    localparam int OFS_W = 6;
    localparam int FULL_W = BLK_W + OFS_W;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [6:0] OFS_TYPE_HIGH = 7'h00;
    localparam logic [6:0] OFS_TYPE_LOW = 7'h01;
    localparam logic [6:0] OFS_REVISION = 7'h02;
    localparam logic [6:0] OFS_VENDOR0 = 7'h03;
    localparam logic [6:0] OFS_VENDOR1 = 7'h04;
    localparam logic [6:0] OFS_CAPABILITY = 7'h05;
    localparam logic [6:0] OFS_WR_RECOVERY = 7'h06;
    localparam logic [6:0] OFS_LEGACY_CFG = 7'h0b;
    localparam logic [6:0] OFS_PROTECT_LOW = 7'h0c;
    localparam logic [6:0] OFS_PROTECT_HIGH = 7'h0d;
    localparam logic [6:0] OFS_IO_CFG = 7'h0e;
    localparam logic [6:0] OFS_DEVICE_CFG = 7'h12;
    localparam logic [6:0] OFS_TEMP_CLR = 7'h13;
    localparam logic [6:0] OFS_ERR_CLR = 7'h14;
    localparam logic [6:0] OFS_SENSOR_CFG = 7'h1a;
    localparam logic [6:0] OFS_INT_CFG = 7'h1b;
    localparam logic [6:0] OFS_HIGH_LIM_L = 7'h1c;
    localparam logic [6:0] OFS_HIGH_LIM_H = 7'h1d;
    localparam logic [6:0] OFS_LOW_LIM_L = 7'h1e;
    localparam logic [6:0] OFS_LOW_LIM_H = 7'h1f;
    localparam logic [6:0] OFS_CRIT_HIGH_L = 7'h20;
    localparam logic [6:0] OFS_CRIT_HIGH_H = 7'h21;
    localparam logic [6:0] OFS_CRIT_LOW_L = 7'h22;
    localparam logic [6:0] OFS_CRIT_LOW_H = 7'h23;
    localparam logic [6:0] OFS_RESOLUTION = 7'h24;
    localparam logic [6:0] OFS_HYSTERESIS = 7'h25;
    localparam logic [6:0] OFS_DEVICE_STATE = 7'h30;
    localparam logic [6:0] OFS_TEMP_L = 7'h31;
    localparam logic [6:0] OFS_TEMP_H = 7'h32;
    localparam logic [6:0] OFS_TEMP_STATUS = 7'h33;
    localparam logic [6:0] OFS_ERR_STATUS = 7'h34;
    localparam logic [6:0] OFS_PROG_ABORT = 7'h35;

    // ****************************************
    // reset values and masks
    // ****************************************
    localparam logic [7:0] RST_CAPABILITY = 8'h03;
    localparam logic [7:0] RST_WR_RECOVERY = 8'h52;
    localparam logic [7:0] RST_HIGH_LIM_L = 8'h70;
    localparam logic [7:0] RST_HIGH_LIM_H = 8'h03;
    localparam logic [7:0] RST_CRIT_HIGH_L = 8'h50;
    localparam logic [7:0] RST_CRIT_HIGH_H = 8'h05;
    localparam logic [7:0] RST_RESOLUTION = 8'h01;
    localparam logic [7:0] RST_HYSTERESIS = 8'h01;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] MASK_ALL = 8'hff;
    localparam logic [7:0] MASK_NONE = 8'h00;
    localparam logic [7:0] REVISION_MASK = 8'h3e;
    localparam logic [7:0] CAPABILITY_MASK = 8'h03;
    localparam logic [7:0] WR_RECOVERY_MASK = 8'hf3;
    localparam logic [7:0] LEGACY_CFG_WMASK = 8'h0f;
    localparam logic [7:0] DEVICE_CFG_WMASK = 8'hff;
    localparam logic [7:0] INT_CFG_WMASK = 8'hff;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic valid;
        logic write;
        logic space_select;
        logic [3:0] blk;
        logic [5:0] ofs;
        logic [7:0] wdata;
    } hvrb_acc_t;

    typedef struct packed {
        logic [7:0] temp_cond;
        logic [7:0] err_cond;
        logic [7:0] device_state;
        logic [15:0] sensed_temp;
        logic [7:0] prog_abort;
    } hvrb_live_t;

    typedef struct packed {
        logic [7:0] legacy_serial_config;
        logic [15:0] block_protect;
        logic [7:0] interface_io_config;
        logic [7:0] device_config;
        logic [7:0] sensor_config;
        logic [7:0] interrupt_config;
        logic [15:0] high_limit;
        logic [15:0] low_limit;
        logic [15:0] crit_high_limit;
        logic [15:0] crit_low_limit;
        logic [7:0] sensor_resolution;
        logic [7:0] sensor_hysteresis;
    } hvrb_cfg_t;

endpackage

// ===== hvrb_register_bank.sv
`timescale 1ns/1ps
module hvrb_register_bank #(
    parameter int REG_COUNT = hvrb_pkg::REG_COUNT,
    // identity bytes: values arbitrary
    parameter logic [7:0] TYPE_HIGH = 8'ha5,
    parameter logic [7:0] TYPE_LOW = 8'h3c,
    parameter logic [7:0] REVISION = 8'h10,
    parameter logic [7:0] VENDOR0 = 8'h12,
    parameter logic [7:0] VENDOR1 = 8'h34
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic I_CE,
    input wire hvrb_pkg::hvrb_acc_t I_ACC,
    input wire hvrb_pkg::hvrb_live_t I_LIVE,
    output logic [7:0] O_RDATA,
    output logic O_RVALID,
    output logic O_WACK,
    output logic [7:0] O_TEMP_STATUS,
    output logic [7:0] O_ERR_STATUS,
    output hvrb_pkg::hvrb_cfg_t O_CFG
);

    // ****************************************
    // parameter check
    // ****************************************
    if (REG_COUNT != hvrb_pkg::REG_COUNT) begin : g_bad_count
        $error("register count must be 128");
    end

    // ****************************************
    // decode functions
    // ****************************************
    function automatic logic [7:0] wmask(input logic [6:0] a);
        case (a)
            hvrb_pkg::OFS_PROTECT_LOW,
            hvrb_pkg::OFS_PROTECT_HIGH,
            hvrb_pkg::OFS_IO_CFG,
            hvrb_pkg::OFS_SENSOR_CFG,
            hvrb_pkg::OFS_HIGH_LIM_L,
            hvrb_pkg::OFS_HIGH_LIM_H,
            hvrb_pkg::OFS_LOW_LIM_L,
            hvrb_pkg::OFS_LOW_LIM_H,
            hvrb_pkg::OFS_CRIT_HIGH_L,
            hvrb_pkg::OFS_CRIT_HIGH_H,
            hvrb_pkg::OFS_CRIT_LOW_L,
            hvrb_pkg::OFS_CRIT_LOW_H,
            hvrb_pkg::OFS_RESOLUTION,
            hvrb_pkg::OFS_HYSTERESIS: wmask = hvrb_pkg::MASK_ALL;
            hvrb_pkg::OFS_LEGACY_CFG: wmask = hvrb_pkg::LEGACY_CFG_WMASK;
            hvrb_pkg::OFS_DEVICE_CFG: wmask = hvrb_pkg::DEVICE_CFG_WMASK;
            hvrb_pkg::OFS_INT_CFG: wmask = hvrb_pkg::INT_CFG_WMASK;
            default: wmask = hvrb_pkg::MASK_NONE;
        endcase
    endfunction

    function automatic logic [7:0] rst_val(input logic [6:0] a);
        case (a)
            hvrb_pkg::OFS_HIGH_LIM_L: rst_val = hvrb_pkg::RST_HIGH_LIM_L;
            hvrb_pkg::OFS_HIGH_LIM_H: rst_val = hvrb_pkg::RST_HIGH_LIM_H;
            hvrb_pkg::OFS_CRIT_HIGH_L: rst_val = hvrb_pkg::RST_CRIT_HIGH_L;
            hvrb_pkg::OFS_CRIT_HIGH_H: rst_val = hvrb_pkg::RST_CRIT_HIGH_H;
            hvrb_pkg::OFS_RESOLUTION: rst_val = hvrb_pkg::RST_RESOLUTION;
            hvrb_pkg::OFS_HYSTERESIS: rst_val = hvrb_pkg::RST_HYSTERESIS;
            default: rst_val = hvrb_pkg::RST_ZERO;
        endcase
    endfunction

    // ****************************************
    // address decode
    // ****************************************
    logic [hvrb_pkg::FULL_W-1:0] full_addr;
    logic [6:0] idx;
    logic in_range;
    logic acc_ok;
    logic wr_ok;
    logic rd_ok;
    logic [7:0] cur_wmask;

    assign full_addr = {I_ACC.blk, I_ACC.ofs};
    assign idx = full_addr[6:0];
    assign in_range = (full_addr[hvrb_pkg::FULL_W-1:7] == 3'h0);
    assign acc_ok = I_ACC.valid && !I_ACC.space_select;
    assign wr_ok = acc_ok && I_ACC.write;
    assign rd_ok = acc_ok && !I_ACC.write;
    assign cur_wmask = in_range ? wmask(idx) : hvrb_pkg::MASK_NONE;

    // ****************************************
    // writable storage
    // ****************************************
    logic [7:0] reg_q [0:hvrb_pkg::REG_COUNT-1];

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            for (int i = 0; i < hvrb_pkg::REG_COUNT; i++) begin
                reg_q[i] <= rst_val(7'(i));
            end
        end else if (I_CE && wr_ok) begin
            reg_q[idx] <= (reg_q[idx] & ~cur_wmask) | (I_ACC.wdata & cur_wmask);
        end
    end

    // ****************************************
    // clear commands
    // ****************************************
    logic [7:0] temp_cmd;
    logic [7:0] err_cmd;
    logic temp_cmd_hit;
    logic err_cmd_hit;

    assign temp_cmd_hit = wr_ok && in_range && (idx == hvrb_pkg::OFS_TEMP_CLR);
    assign err_cmd_hit = wr_ok && in_range && (idx == hvrb_pkg::OFS_ERR_CLR);

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            temp_cmd <= 8'h00;
            err_cmd <= 8'h00;
        end else if (I_CE) begin
            temp_cmd <= temp_cmd_hit ? I_ACC.wdata : 8'h00;
            err_cmd <= err_cmd_hit ? I_ACC.wdata : 8'h00;
        end
    end

    // ****************************************
    // latched status
    // ****************************************
    logic [7:0] temp_status;
    logic [7:0] err_status;
    logic [7:0] next_temp_status;
    logic [7:0] next_err_status;

    assign next_temp_status = I_LIVE.temp_cond | (temp_status & ~temp_cmd);
    assign next_err_status = I_LIVE.err_cond | (err_status & ~err_cmd);

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            temp_status <= 8'h00;
            err_status <= 8'h00;
        end else if (I_CE) begin
            temp_status <= next_temp_status;
            err_status <= next_err_status;
        end
    end

    // ****************************************
    // read path
    // ****************************************
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        if (in_range) begin
            case (idx)
                hvrb_pkg::OFS_TYPE_HIGH: next_rdata = TYPE_HIGH;
                hvrb_pkg::OFS_TYPE_LOW: next_rdata = TYPE_LOW;
                hvrb_pkg::OFS_REVISION: next_rdata = REVISION & hvrb_pkg::REVISION_MASK;
                hvrb_pkg::OFS_VENDOR0: next_rdata = VENDOR0;
                hvrb_pkg::OFS_VENDOR1: next_rdata = VENDOR1;
                hvrb_pkg::OFS_CAPABILITY: next_rdata = hvrb_pkg::RST_CAPABILITY & hvrb_pkg::CAPABILITY_MASK;
                hvrb_pkg::OFS_WR_RECOVERY: next_rdata = hvrb_pkg::RST_WR_RECOVERY & hvrb_pkg::WR_RECOVERY_MASK;
                hvrb_pkg::OFS_TEMP_CLR: next_rdata = temp_cmd;
                hvrb_pkg::OFS_ERR_CLR: next_rdata = err_cmd;
                hvrb_pkg::OFS_DEVICE_STATE: next_rdata = I_LIVE.device_state;
                hvrb_pkg::OFS_TEMP_L: next_rdata = I_LIVE.sensed_temp[7:0];
                hvrb_pkg::OFS_TEMP_H: next_rdata = I_LIVE.sensed_temp[15:8];
                hvrb_pkg::OFS_TEMP_STATUS: next_rdata = temp_status;
                hvrb_pkg::OFS_ERR_STATUS: next_rdata = err_status;
                hvrb_pkg::OFS_PROG_ABORT: next_rdata = I_LIVE.prog_abort;
                default: next_rdata = reg_q[idx] & wmask(idx);
            endcase
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            O_RDATA <= 8'h00;
            O_RVALID <= 1'b0;
            O_WACK <= 1'b0;
        end else if (I_CE) begin
            O_RVALID <= rd_ok;
            O_WACK <= wr_ok;
            if (rd_ok) begin
                O_RDATA <= next_rdata;
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign O_TEMP_STATUS = temp_status;
    assign O_ERR_STATUS = err_status;
    assign O_CFG.legacy_serial_config = reg_q[hvrb_pkg::OFS_LEGACY_CFG];
    assign O_CFG.block_protect = {reg_q[hvrb_pkg::OFS_PROTECT_HIGH], reg_q[hvrb_pkg::OFS_PROTECT_LOW]};
    assign O_CFG.interface_io_config = reg_q[hvrb_pkg::OFS_IO_CFG];
    assign O_CFG.device_config = reg_q[hvrb_pkg::OFS_DEVICE_CFG];
    assign O_CFG.sensor_config = reg_q[hvrb_pkg::OFS_SENSOR_CFG];
    assign O_CFG.interrupt_config = reg_q[hvrb_pkg::OFS_INT_CFG];
    assign O_CFG.high_limit = {reg_q[hvrb_pkg::OFS_HIGH_LIM_H], reg_q[hvrb_pkg::OFS_HIGH_LIM_L]};
    assign O_CFG.low_limit = {reg_q[hvrb_pkg::OFS_LOW_LIM_H], reg_q[hvrb_pkg::OFS_LOW_LIM_L]};
    assign O_CFG.crit_high_limit = {reg_q[hvrb_pkg::OFS_CRIT_HIGH_H], reg_q[hvrb_pkg::OFS_CRIT_HIGH_L]};
    assign O_CFG.crit_low_limit = {reg_q[hvrb_pkg::OFS_CRIT_LOW_H], reg_q[hvrb_pkg::OFS_CRIT_LOW_L]};
    assign O_CFG.sensor_resolution = reg_q[hvrb_pkg::OFS_RESOLUTION];
    assign O_CFG.sensor_hysteresis = reg_q[hvrb_pkg::OFS_HYSTERESIS];

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_RST);

    rsvd_read_zero_a: assert property (
        (I_CE && rd_ok && in_range && idx >= 7'h36) |=> (O_RVALID && O_RDATA == 8'h00))
        else $error("reserved address did not read zero");

    out_range_zero_a: assert property (
        (I_CE && rd_ok && !in_range) |=> (O_RVALID && O_RDATA == 8'h00))
        else $error("address above range did not read zero");

    space_ignore_a: assert property (
        (I_CE && I_ACC.valid && I_ACC.space_select) |=> (!O_RVALID && !O_WACK))
        else $error("nonvolatile access answered by register bank");

    ro_write_keep_a: assert property (
        (I_CE && wr_ok && cur_wmask == 8'h00) |=> $stable(O_CFG))
        else $error("write to read-only location changed config");

    rsvd_write_ack_a: assert property (
        (I_CE && wr_ok && !in_range) |=> (O_WACK && $stable(O_CFG)))
        else $error("reserved write not accepted cleanly");

    zero_cmd_idle_a: assert property (
        (I_CE && temp_cmd_hit && I_ACC.wdata == 8'h00) |=> (temp_cmd == 8'h00))
        else $error("zero write to clear command took effect");

    temp_clear_a: assert property (
        (I_CE && |temp_cmd) |=> ((temp_status & $past(temp_cmd) & ~$past(I_LIVE.temp_cond)) == 8'h00))
        else $error("temperature status not cleared");

    err_clear_a: assert property (
        (I_CE && |err_cmd) |=> ((err_status & $past(err_cmd) & ~$past(I_LIVE.err_cond)) == 8'h00))
        else $error("error status not cleared");

    status_hold_a: assert property (
        (I_CE && temp_cmd == 8'h00) |=> ((temp_status & $past(temp_status)) == $past(temp_status)))
        else $error("latched temperature status dropped without clear");

    cond_sets_a: assert property (
        (I_CE && |I_LIVE.err_cond) |=> ((err_status & $past(I_LIVE.err_cond)) == $past(I_LIVE.err_cond)))
        else $error("present condition not latched");

    type_code_a: assert property (
        (I_CE && rd_ok && in_range && idx == hvrb_pkg::OFS_TYPE_LOW) |=> (O_RDATA == TYPE_LOW))
        else $error("device type low byte wrong");

    limit_write_a: assert property (
        (I_CE && wr_ok && in_range && idx == hvrb_pkg::OFS_HIGH_LIM_L)
        |=> (O_CFG.high_limit[7:0] == $past(I_ACC.wdata)))
        else $error("read-write limit register not written");

    type_high_a: assert property (
        (I_CE && rd_ok && in_range && idx == hvrb_pkg::OFS_TYPE_HIGH)
        |=> (O_RDATA == TYPE_HIGH))
        else $error("device type high byte wrong");

    read_answer_a: assert property (
        (I_CE && rd_ok)
        |=> (O_RVALID && !O_WACK))
        else $error("read not answered");

    write_answer_a: assert property (
        (I_CE && wr_ok)
        |=> (O_WACK && !O_RVALID))
        else $error("write not acknowledged");

    idle_quiet_a: assert property (
        (I_CE && !acc_ok)
        |=> (!O_RVALID && !O_WACK))
        else $error("answer without access");

    rdata_hold_a: assert property (
        !(I_CE && rd_ok)
        |=> $stable(O_RDATA))
        else $error("read data moved without read");

    cfg_freeze_a: assert property (
        !I_CE
        |=> $stable(O_CFG))
        else $error("config moved with enable low");

    status_freeze_a: assert property (
        !I_CE
        |=> ($stable(temp_status) && $stable(err_status)))
        else $error("status moved with enable low");

    rsvd_low_a: assert property (
        (I_CE && rd_ok && in_range && idx >= 7'h07 && idx <= 7'h0a)
        |=> (O_RDATA == 8'h00))
        else $error("low reserved block not zero");

    rsvd_mid_a: assert property (
        (I_CE && rd_ok && in_range && ((idx >= 7'h0f && idx <= 7'h11) || (idx >= 7'h15 && idx <= 7'h19)))
        |=> (O_RDATA == 8'h00))
        else $error("middle reserved block not zero");

    rsvd_upper_a: assert property (
        (I_CE && rd_ok && in_range && idx >= 7'h26 && idx <= 7'h2f)
        |=> (O_RDATA == 8'h00))
        else $error("upper reserved block not zero");

    legacy_bits_a: assert property (
        (I_CE && rd_ok && in_range && idx == hvrb_pkg::OFS_LEGACY_CFG)
        |=> (O_RDATA[7:4] == 4'h0))
        else $error("legacy reserved bits not zero");

    upper_addr_a: assert property (
        (I_CE && rd_ok && I_ACC.blk == 4'h1 && I_ACC.ofs == 6'h00)
        |=> (O_RDATA == 8'h00))
        else $error("block bits not used as address");

    live_temp_a: assert property (
        (I_CE && rd_ok && in_range && idx == hvrb_pkg::OFS_TEMP_H)
        |=> (O_RDATA == $past(I_LIVE.sensed_temp[15:8])))
        else $error("sensed temperature read wrong");

    status_read_a: assert property (
        (I_CE && rd_ok && in_range && idx == hvrb_pkg::OFS_ERR_STATUS)
        |=> (O_RDATA == $past(err_status)))
        else $error("error status read wrong");

    err_hold_a: assert property (
        (I_CE && err_cmd == 8'h00)
        |=> ((err_status & $past(err_status)) == $past(err_status)))
        else $error("latched error status dropped without clear");

    temp_sets_a: assert property (
        (I_CE && |I_LIVE.temp_cond)
        |=> ((temp_status & $past(I_LIVE.temp_cond)) == $past(I_LIVE.temp_cond)))
        else $error("temperature condition not latched");

    err_zero_cmd_a: assert property (
        (I_CE && err_cmd_hit && I_ACC.wdata == 8'h00)
        |=> (err_cmd == 8'h00))
        else $error("zero write to error clear took effect");

    hyst_write_a: assert property (
        (I_CE && wr_ok && in_range && idx == hvrb_pkg::OFS_HYSTERESIS)
        |=> (O_CFG.sensor_hysteresis == $past(I_ACC.wdata)))
        else $error("hysteresis register not written");

    space_nowrite_a: assert property (
        (I_CE && I_ACC.valid && I_ACC.space_select)
        |=> $stable(O_CFG))
        else $error("nonvolatile access changed config");

    rd_cover_c: cover property (I_CE && rd_ok && in_range ##1 O_RVALID);
    clr_persist_c: cover property (I_CE && |(temp_cmd & I_LIVE.temp_cond));
    clr_done_c: cover property (I_CE && |err_cmd ##1 err_status == 8'h00);
    upper_blk_c: cover property (I_CE && wr_ok && in_range && I_ACC.blk[0]);

endmodule // hvrb_register_bank

// ===== hvrb_host_model.sv
`timescale 1ns/1ps
module hvrb_host_model (
    input wire logic i_clk,
    input wire logic i_rvalid,
    input wire logic i_wack,
    input wire logic [7:0] i_rdata,
    output hvrb_pkg::hvrb_acc_t o_acc
);
    initial begin
        o_acc = '0;
    end

    // ****************************************
    // one access, held until the taking edge
    // ****************************************
    task automatic access(input logic wr, input logic ss, input logic [9:0] addr, input logic [7:0] wd,
                          output logic got_r, output logic got_w, output logic [7:0] rd);
        @(posedge i_clk);
        #1;
        o_acc.valid = 1'h1;
        o_acc.write = wr;
        o_acc.space_select = ss;
        o_acc.blk = addr[9:6];
        o_acc.ofs = addr[5:0];
        o_acc.wdata = wd;
        @(posedge i_clk);
        #1;
        got_r = i_rvalid;
        got_w = i_wack;
        rd = i_rdata;
        // released address and data lines show the inverse of the last value
        o_acc.valid = 1'h0;
        o_acc.blk = ~addr[9:6];
        o_acc.ofs = ~addr[5:0];
        o_acc.wdata = ~wd;
    endtask

    // ****************************************
    // read-modify-write
    // ****************************************
    task automatic rmw(input logic [9:0] addr, input logic [7:0] keep, input logic [7:0] val);
        logic r;
        logic w;
        logic [7:0] old;
        access(1'h0, 1'h0, addr, 8'h00, r, w, old);
        access(1'h1, 1'h0, addr, (old & keep) | (val & ~keep), r, w, old);
    endtask
endmodule // hvrb_host_model

// ===== hvrb_register_bank_tb.sv
`timescale 1ns/1ps
module hvrb_register_bank_tb;
    typedef struct packed {
        logic wr;
        logic [9:0] addr;
        logic [7:0] data;
    } hvrb_row_t;

    logic clk;
    logic rst;
    logic ce;
    hvrb_pkg::hvrb_acc_t acc;
    hvrb_pkg::hvrb_live_t live;
    logic [7:0] rdata;
    logic rvalid;
    logic wack;
    logic [7:0] temp_st;
    logic [7:0] err_st;
    hvrb_pkg::hvrb_cfg_t cfg;
    int err_total;
    int n_checks;
    int cycles;
    logic got_r;
    logic got_w;
    logic [7:0] rd;
    hvrb_row_t rows [36];

    hvrb_register_bank u_hvrb_register_bank (
        .I_CORE_CLK(clk),
        .I_RST(rst),
        .I_CE(ce),
        .I_ACC(acc),
        .I_LIVE(live),
        .O_RDATA(rdata),
        .O_RVALID(rvalid),
        .O_WACK(wack),
        .O_TEMP_STATUS(temp_st),
        .O_ERR_STATUS(err_st),
        .O_CFG(cfg)
    );

    hvrb_host_model u_hvrb_host_model (
        .i_clk(clk),
        .i_rvalid(rvalid),
        .i_wack(wack),
        .i_rdata(rdata),
        .o_acc(acc)
    );

    // ****************************************
    // clock and timeout
    // ****************************************
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        cycles = 0;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_total = err_total + 1;
            complete_run();
        end
    end

    // ****************************************
    // compares and helpers
    // ****************************************
    task automatic cmp_data(input logic [15:0] got, input logic [15:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_flag(input logic got, input logic exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic wr, input logic [9:0] addr, input logic [7:0] d);
        u_hvrb_host_model.access(wr, 1'h0, addr, d, got_r, got_w, rd);
        cmp_flag(got_w, wr);
        cmp_flag(got_r, ~wr);
        if (!wr) begin
            cmp_data({8'h00, rd}, {8'h00, d});
        end
    endtask

    task automatic set_cond(input logic is_err, input logic [7:0] v);
        if (is_err) begin
            live.err_cond = v;
        end else begin
            live.temp_cond = v;
        end
    endtask

    function automatic logic [15:0] status_of(input logic is_err);
        return is_err ? {8'h00, err_st} : {8'h00, temp_st};
    endfunction

    task automatic settle();
        @(posedge clk);
        #1;
    endtask

    task automatic status_seq(input logic is_err);
        logic [9:0] cmd;
        logic [9:0] st_addr;
        cmd = is_err ? 10'h014 : 10'h013;
        st_addr = is_err ? 10'h034 : 10'h033;
        set_cond(is_err, 8'h05);
        settle();
        set_cond(is_err, 8'h00);
        settle();
        cmp_data(status_of(is_err), 16'h0005);
        xfer(1'h0, st_addr, 8'h05);
        xfer(1'h1, cmd, 8'h00);
        settle();
        cmp_data(status_of(is_err), 16'h0005);
        xfer(1'h1, cmd, 8'h01);
        settle();
        cmp_data(status_of(is_err), 16'h0004);
        set_cond(is_err, 8'h04);
        xfer(1'h1, cmd, 8'h04);
        settle();
        cmp_data(status_of(is_err), 16'h0004);
        set_cond(is_err, 8'h00);
        xfer(1'h1, cmd, 8'h04);
        settle();
        cmp_data(status_of(is_err), 16'h0000);
        $display("test status %0d done", is_err);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst = 1'h1;
        ce = 1'h1;
        live = '0;
        live.device_state = 8'h5e;
        live.sensed_temp = 16'h0123;
        live.prog_abort = 8'h0f;
        err_total = 0;
        n_checks = 0;
        rows = '{'{1'h0, 10'h000, 8'ha5}, '{1'h0, 10'h001, 8'h3c}, '{1'h0, 10'h002, 8'h10},
                 '{1'h0, 10'h003, 8'h12}, '{1'h0, 10'h004, 8'h34}, '{1'h0, 10'h005, 8'h03},
                 '{1'h0, 10'h006, 8'h52}, '{1'h0, 10'h01c, 8'h70}, '{1'h0, 10'h01d, 8'h03},
                 '{1'h0, 10'h020, 8'h50}, '{1'h0, 10'h021, 8'h05}, '{1'h0, 10'h024, 8'h01},
                 '{1'h0, 10'h025, 8'h01}, '{1'h1, 10'h000, 8'hff}, '{1'h0, 10'h000, 8'ha5},
                 '{1'h1, 10'h00b, 8'h5a}, '{1'h0, 10'h00b, 8'h0a}, '{1'h1, 10'h007, 8'h77},
                 '{1'h0, 10'h007, 8'h00}, '{1'h1, 10'h05c, 8'h99}, '{1'h0, 10'h01c, 8'h70},
                 '{1'h1, 10'h21c, 8'h99}, '{1'h0, 10'h01c, 8'h70}, '{1'h0, 10'h07f, 8'h00},
                 '{1'h1, 10'h00c, 8'h11}, '{1'h1, 10'h00d, 8'h22}, '{1'h0, 10'h030, 8'h5e},
                 '{1'h1, 10'h030, 8'hff}, '{1'h0, 10'h030, 8'h5e}, '{1'h0, 10'h031, 8'h23},
                 '{1'h0, 10'h032, 8'h01}, '{1'h0, 10'h035, 8'h0f}, '{1'h0, 10'h013, 8'h00},
                 '{1'h0, 10'h014, 8'h00}, '{1'h1, 10'h01e, 8'h44}, '{1'h1, 10'h023, 8'h66}};
        repeat (12) @(posedge clk);
        #1;
        rst = 1'h0;
        settle();
        cmp_data(cfg.high_limit, 16'h0370);
        cmp_data(cfg.crit_high_limit, 16'h0550);
        cmp_data({cfg.sensor_resolution, cfg.sensor_hysteresis}, 16'h0101);
        cmp_data({temp_st, err_st}, 16'h0000);
        $display("test reset done");
        foreach (rows[i]) begin
            xfer(rows[i].wr, rows[i].addr, rows[i].data);
        end
        cmp_data(cfg.block_protect, 16'h2211);
        cmp_data({8'h00, cfg.legacy_serial_config}, 16'h000a);
        cmp_data(cfg.low_limit, 16'h0044);
        cmp_data(cfg.crit_low_limit, 16'h6600);
        $display("test table done");
        u_hvrb_host_model.access(1'h1, 1'h1, 10'h00b, 8'h00, got_r, got_w, rd);
        cmp_flag(got_w, 1'h0);
        xfer(1'h0, 10'h00b, 8'h0a);
        $display("test space select done");
        settle();
        ce = 1'h0;
        u_hvrb_host_model.access(1'h1, 1'h0, 10'h01c, 8'h99, got_r, got_w, rd);
        cmp_flag(got_w, 1'h0);
        cmp_flag(got_r, 1'h0);
        ce = 1'h1;
        xfer(1'h0, 10'h01c, 8'h70);
        $display("test clock enable done");
        status_seq(1'h0);
        status_seq(1'h1);
        xfer(1'h1, 10'h00e, 8'h50);
        u_hvrb_host_model.rmw(10'h00e, 8'hf0, 8'h0a);
        cmp_data({8'h00, cfg.interface_io_config}, 16'h005a);
        $display("test read modify write done");
        settle();
        rst = 1'h1;
        repeat (2) @(posedge clk);
        #1;
        rst = 1'h0;
        cmp_data(cfg.block_protect, 16'h0000);
        cmp_data(cfg.high_limit, 16'h0370);
        $display("test second reset done");
        complete_run();
    end
endmodule // hvrb_register_bank_tb
